// ==== design/pbs_mem_array.sv ====
// Storage array with lane-masked writes and a registered read port
`timescale 1ns/1ps
module pbs_mem_array #(
  parameter int AW    = pbs_pkg::ADDR_W_DEF,
  parameter int LANES = pbs_pkg::LANES_WIDE
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pipeline side
  pbs_mem_if.mem   m
);

  localparam int DW = LANES * pbs_pkg::LANE_W;

  typedef struct packed {
    logic [DW-1:0] rd;
  } pbs_mem_state_t;

  logic [DW-1:0]  store [2**AW];
  pbs_mem_state_t st;
  pbs_mem_state_t next_st;

  always_comb begin
    next_st = st;
    if (m.en) begin
      next_st.rd = store[m.rd_addr];
      // Write forwarding
      // Same-edge bypass
      // A write landing on the read address in the same edge is
      // forwarded, so back-to-back write then read needs no gap.
      for (int i = 0; i < LANES; i++) begin
        if (m.wr_en && m.wr_lanes[i] && m.wr_addr == m.rd_addr) begin
          next_st.rd[i*pbs_pkg::LANE_W +: pbs_pkg::LANE_W] =
            m.wr_data[i*pbs_pkg::LANE_W +: pbs_pkg::LANE_W];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < LANES; i++) begin
      if (m.wr_en && m.wr_lanes[i]) begin
        store[m.wr_addr][i*pbs_pkg::LANE_W +: pbs_pkg::LANE_W] <=
          m.wr_data[i*pbs_pkg::LANE_W +: pbs_pkg::LANE_W];
      end
    end
  end

  assign m.rd_data = st.rd;

  bypass_fwd_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    m.en && m.wr_en && m.wr_addr == m.rd_addr && (&m.wr_lanes)
    |=> m.rd_data == $past(m.wr_data))
    else $error("Forwarded write data missing on read");

endmodule // pbs_mem_array

// ==== design/pbs_mem_if.sv ====
// Connection between the port pipeline and its storage array
`timescale 1ns/1ps
interface pbs_mem_if #(
  parameter int AW    = pbs_pkg::ADDR_W_DEF,
  parameter int LANES = pbs_pkg::LANES_WIDE
);
  logic                          en;
  logic [AW-1:0]                 rd_addr;
  logic                          wr_en;
  logic [AW-1:0]                 wr_addr;
  logic [LANES-1:0]              wr_lanes;
  logic [LANES*pbs_pkg::LANE_W-1:0] wr_data;
  logic [LANES*pbs_pkg::LANE_W-1:0] rd_data;

  modport ctrl (
    output en, rd_addr, wr_en, wr_addr, wr_lanes, wr_data,
    input  rd_data
  );
  modport mem (
    input  en, rd_addr, wr_en, wr_addr, wr_lanes, wr_data,
    output rd_data
  );
endinterface

// ==== design/pbs_pkg.sv ====
// Shared constants for the pipelined burst SRAM port
package pbs_pkg;

  // Lane layout: eight data bits plus one extra bit per lane
  localparam int LANE_BITS  = 8;
  localparam int LANE_W     = 9;
  localparam int EXTRA_POS  = 8;

  // Documented organisation defaults
  localparam int ADDR_W_DEF = 17;
  localparam int LANES_WIDE = 4;
  localparam int LANES_NARW = 2;

  // Burst counter
  localparam int            BURST_CNT_W = 2;
  localparam logic [1:0]    CNT_START   = 2'h0;
  localparam logic [1:0]    CNT_STEP    = 2'h1;
  localparam logic [1:0]    CNT_LAST    = 2'h3;

  // Burst order strap level that selects interleaved order
  localparam logic          ORDER_INTERLEAVE = 1'b1;

  // Reset values
  localparam logic          OE_RESET   = 1'b0;
  localparam logic [1:0]    SYNC_RESET = 2'h0;

  typedef enum logic {
    PBS_IDLE  = 1'b0,
    PBS_BURST = 1'b1
  } pbs_burst_t;

endpackage

// ==== design/pbs_sram_port.sv ====
// Pipelined burst SRAM access port, device side
`timescale 1ns/1ps
// Function
// - Select needs all three chip selects true
// - Selected load captures address and direction
// - Data slot two enabled edges later
// - Advance steps counter, uses internal address
// - Direction input ignored while advancing
// - Load direction fixes whole burst direction
// - Strap high: start XOR count order
// - Strap low: start plus count modulo four
// - Counter wraps after fourth beat, continues
// - Load while deselected starts stop cycle
// - Bus released two enabled edges after stop
// - Stop leaves pipelined transfers to complete
// - Suspended edge is ignored entirely
// - Suspend holds registers and driven data
// - Suspended edges excluded from latency count
// - Data bus stays driven across suspended edges
// - Active-low select per nine-bit lane
// - Several lanes writable in one cycle
// - Narrow build has only two lanes
// - Any cycle order, no turnaround gap
// - Output enable high forces bus off
// - Stop cycle terminates burst in progress
// - Sleep request freezes clock, keeps data
module pbs_sram_port #(
  parameter int AW    = pbs_pkg::ADDR_W_DEF,
  parameter int LANES = pbs_pkg::LANES_WIDE
) (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          arst_n,
  // Command inputs
  input  wire logic [AW-1:0]                 address,
  input  wire logic                          read_write_n,
  input  wire logic                          advance_or_load,
  input  wire logic                          chip_sel1_n,
  input  wire logic                          chip_sel2_n,
  input  wire logic                          chip_sel_high,
  input  wire logic                          clock_enable_n,
  input  wire logic [LANES-1:0]              byte_write_sel_n,
  // Static and asynchronous controls
  input  wire logic                          output_en_n,
  input  wire logic                          burst_order_sel,
  input  wire logic                          sleep_request,
  // Data bus, split into in, out and enable
  input  wire logic [LANES*pbs_pkg::LANE_BITS-1:0] dq_in,
  output wire logic [LANES*pbs_pkg::LANE_BITS-1:0] dq_out,
  input  wire logic [LANES-1:0]              lane_extra_bits_in,
  output wire logic [LANES-1:0]              lane_extra_bits_out,
  output wire logic                          dq_oe
);

  if (!(LANES == pbs_pkg::LANES_WIDE || LANES == pbs_pkg::LANES_NARW)
      || AW < pbs_pkg::BURST_CNT_W + 1) begin : g_bad_cfg
    $error("Unsupported lane count or address width");
  end

  localparam int LB = pbs_pkg::LANE_BITS;
  localparam int LW = pbs_pkg::LANE_W;

  typedef struct packed {
    pbs_pkg::pbs_burst_t          burst;
    logic                         bwr;
    logic [AW-1:0]                base;
    logic [1:0]                   cnt;
    logic                         v1;
    logic                         w1;
    logic [AW-1:0]                a1;
    logic [LANES-1:0]             b1;
    logic                         v2;
    logic                         w2;
    logic [AW-1:0]                a2;
    logic [LANES-1:0]             b2;
    logic                         oe;
  } pbs_state_t;

  logic [1:0] rsync;
  logic       rst_n;
  logic       en;
  logic       sel;
  logic       is_load;
  logic       is_stop;
  pbs_state_t st;
  pbs_state_t next_st;

  pbs_mem_if #(.AW(AW), .LANES(LANES)) m ();

  // Low two address bits of a burst beat
  function automatic logic [1:0] beat_lo(input logic [1:0] start,
                                         input logic [1:0] count,
                                         input logic       order);
    logic [1:0] r;
    r = '0;
    if (order == pbs_pkg::ORDER_INTERLEAVE) begin
      r = start ^ count;
    end else begin
      r = start + count;
    end
    return r;
  endfunction

  // Reset release through two flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rsync <= pbs_pkg::SYNC_RESET;
    end else begin
      rsync <= {rsync[0], 1'b1};
    end
  end
  assign rst_n = rsync[1];

  // Sleep gates edge
  // Sleep is treated as a held clock; the array keeps its contents.
  assign en = !clock_enable_n && !sleep_request;

  assign sel     = !chip_sel1_n && !chip_sel2_n && chip_sel_high;
  assign is_load = !advance_or_load && sel;
  assign is_stop = !advance_or_load && !sel;

  always_comb begin
    next_st = st;
    if (en) begin
      next_st.v2 = st.v1;
      next_st.w2 = st.w1;
      next_st.a2 = st.a1;
      next_st.b2 = st.b1;
      next_st.oe = st.v1 && !st.w1;
      if (is_load) begin
        next_st.burst = pbs_pkg::PBS_BURST;
        next_st.bwr   = !read_write_n;
        next_st.base  = address;
        next_st.cnt   = pbs_pkg::CNT_START;
        next_st.v1    = 1'b1;
        next_st.w1    = !read_write_n;
        next_st.a1    = address;
        next_st.b1    = byte_write_sel_n;
      end else if (is_stop) begin
        next_st.burst = pbs_pkg::PBS_IDLE;
        next_st.v1    = 1'b0;
      end else if (st.burst == pbs_pkg::PBS_BURST) begin
        next_st.cnt = st.cnt + pbs_pkg::CNT_STEP;
        next_st.v1  = 1'b1;
        next_st.w1  = st.bwr;
        next_st.a1  = {st.base[AW-1:2],
                       beat_lo(st.base[1:0], next_st.cnt,
                               burst_order_sel)};
        next_st.b1  = byte_write_sel_n;
      end else begin
        next_st.v1 = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st    <= '0;
      st.oe <= pbs_pkg::OE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Storage side: read at the first enabled edge, write at the second
  assign m.en       = en;
  assign m.rd_addr  = st.a1;
  assign m.wr_en    = en && st.v2 && st.w2;
  assign m.wr_addr  = st.a2;
  assign m.wr_lanes = ~st.b2;

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign m.wr_data[i*LW +: LW] = {lane_extra_bits_in[i],
                                    dq_in[i*LB +: LB]};
    assign dq_out[i*LB +: LB]    = m.rd_data[i*LW +: LB];
    assign lane_extra_bits_out[i] = m.rd_data[i*LW+pbs_pkg::EXTRA_POS];
  end

  // Asynchronous output gate
  // The only path not straight from a flop: the pin must drop
  // without waiting for a clock edge.
  assign dq_oe = st.oe && !output_en_n;

  pbs_mem_array #(.AW(AW), .LANES(LANES)) u_array (
    .mclk  (mclk),
    .rst_n (rst_n),
    .m     (m)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  load_capture_a: assert property (
    en && is_load |=> st.v1 && st.a1 == $past(address)
      && st.w1 == !$past(read_write_n))
    else $error("Load not captured");

  chip_select_a: assert property (
    en && !advance_or_load && (chip_sel1_n || chip_sel2_n
      || !chip_sel_high) |=> !st.v1)
    else $error("Operation started while deselected");

  read_slot_a: assert property (
    en && is_load && read_write_n ##1 en |=> st.oe)
    else $error("Read data not driven in its slot");

  suspend_lat_a: assert property (
    en && is_load && read_write_n ##1 (!en)[*2] ##1 en |=> st.oe)
    else $error("Suspended edges counted toward latency");

  write_slot_a: assert property (
    en && is_load && !read_write_n ##1 en ##1 en
      |-> m.wr_en && m.wr_addr == $past(address, 2)
      && m.wr_lanes == ~$past(byte_write_sel_n, 2))
    else $error("Write not stored in its slot");

  hold_state_a: assert property (
    !en |=> $stable(st) && $stable(dq_out))
    else $error("State moved on a suspended edge");

  desel_hiz_a: assert property (
    en && is_stop ##1 en |=> !st.oe)
    else $error("Bus not released after stop");

  pipe_keep_a: assert property (
    en && is_stop && st.v1 && !st.w1 |=> st.oe)
    else $error("Stop cancelled a pending read");

  rw_ignore_a: assert property (
    en && advance_or_load && st.burst == pbs_pkg::PBS_BURST
      |=> st.w1 == $past(st.bwr) && st.v1)
    else $error("Burst direction changed");

  interleave_a: assert property (
    en && advance_or_load && st.burst == pbs_pkg::PBS_BURST
      && burst_order_sel |=> st.a1[1:0] == (st.base[1:0] ^ st.cnt))
    else $error("Interleaved beat address wrong");

  linear_a: assert property (
    en && advance_or_load && st.burst == pbs_pkg::PBS_BURST
      && !burst_order_sel
      |=> st.a1[1:0] == 2'(st.base[1:0] + st.cnt))
    else $error("Linear beat address wrong");

  wrap_a: assert property (
    en && advance_or_load && st.burst == pbs_pkg::PBS_BURST
      && st.cnt == pbs_pkg::CNT_LAST
      |=> st.cnt == pbs_pkg::CNT_START && st.a1 == st.base)
    else $error("Burst counter did not wrap to start");

  stop_burst_a: assert property (
    en && is_stop |=> st.burst == pbs_pkg::PBS_IDLE)
    else $error("Burst survived a stop cycle");

  idle_cycle_a: assert property (
    en && advance_or_load && st.burst == pbs_pkg::PBS_IDLE
      |=> !st.v1 ##1 (!en || !st.oe))
    else $error("Idle advance started an operation");

  pins_off_a: assert property (
    output_en_n |-> !dq_oe)
    else $error("Bus driven with output enable high");

  sleep_hold_a: assert property (
    sleep_request |=> $stable(st))
    else $error("State moved during sleep");

  burst_four_c: cover property (
    en && is_load ##1 (en && advance_or_load)[*4]);
  wr_then_rd_c: cover property (
    en && is_load && !read_write_n ##1 en && is_load && read_write_n);
  suspend_rd_c: cover property (st.oe ##1 !en ##1 !en);
  stop_mid_c: cover property (
    en && st.burst == pbs_pkg::PBS_BURST && is_stop);

endmodule // pbs_sram_port

// ==== test/pbs_ctrl_model.sv ====
// Memory controller model driving the synchronous SRAM bus
`timescale 1ns/1ps
module pbs_ctrl_model #(
  parameter int AW = 6
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // Command outputs
  output logic [AW-1:0]    address,
  output logic             read_write_n,
  output logic             advance_or_load,
  output logic             chip_sel1_n,
  output logic             chip_sel2_n,
  output logic             chip_sel_high,
  output logic             clock_enable_n,
  output logic             sleep_request,
  output logic [3:0]       byte_write_sel_n,
  // Data bus
  output logic [31:0]      dq_in,
  output logic [3:0]       lane_extra_bits_in,
  input  wire logic [31:0] dq_out,
  input  wire logic [3:0]  lane_extra_bits_out,
  input  wire logic        dq_oe
);
  logic        cur_wr = 1'h0;
  logic [35:0] cur_wd = 36'h0;
  logic        s1_wr;
  logic        s2_wr;
  logic [35:0] s1_wd;
  logic [35:0] s2_wd;
  logic [36:0] obs[$];

  initial begin
    {address, read_write_n, advance_or_load} = '0;
    {chip_sel1_n, chip_sel2_n, chip_sel_high} = 3'h1;
    clock_enable_n = 1'h1;
    sleep_request = 1'h0;
    byte_write_sel_n = 4'hf;
    {lane_extra_bits_in, dq_in} = 36'h0;
  end

  // Each enabled edge records the slot of the command two edges back
  always @(posedge mclk) begin
    if (!arst_n) begin
      s1_wr = 1'h0;
      s2_wr = 1'h0;
    end else if (clock_enable_n == 1'h0 && sleep_request == 1'h0) begin
      obs.push_back({dq_oe, lane_extra_bits_out, dq_out});
      s2_wr = s1_wr;
      s2_wd = s1_wd;
      s1_wr = cur_wr;
      s1_wd = cur_wd;
      #1;
      if (s2_wr) begin
        {lane_extra_bits_in, dq_in} = s2_wd;
      end else begin
        // Released: inverted so stale data can never match by luck
        {lane_extra_bits_in, dq_in} = ~{lane_extra_bits_in, dq_in};
      end
    end
  end

  // One command per edge; kinds 0 load, 1 advance, 2 stop, 3 hold, 4 sleep
  task automatic step(input int k, input logic [AW-1:0] a,
                      input logic rw, input logic [3:0] bw,
                      input logic [2:0] cs, input logic [35:0] wd,
                      input logic wr);
    @(posedge mclk);
    #1;
    clock_enable_n = (k == 3);
    sleep_request = (k == 4);
    advance_or_load = (k == 1);
    // Select pattern per cycle, any order
    {chip_sel1_n, chip_sel2_n, chip_sel_high} = cs;
    address = a;
    read_write_n = rw;
    // Lane selects given on every beat
    byte_write_sel_n = bw;
    cur_wr = wr;
    cur_wd = wd;
  endtask
endmodule // pbs_ctrl_model

// ==== test/pbs_sram_port_tb.sv ====
// Self-checking testbench for the pipelined burst SRAM port
`timescale 1ns/1ps
module pbs_sram_port_tb;
  localparam int AW = 6;
  logic            mclk = 1'h0;
  logic            arst_n = 1'h0;
  logic            output_en_n = 1'h0;
  logic            burst_order_sel = 1'h1;
  logic [AW-1:0]   address;
  logic            read_write_n, advance_or_load, clock_enable_n;
  logic            chip_sel1_n, chip_sel2_n, chip_sel_high;
  logic            sleep_request, dq_oe;
  logic [3:0]      byte_write_sel_n, lane_extra_bits_in;
  logic [3:0]      lane_extra_bits_out;
  logic [31:0]     dq_in, dq_out;
  int              num_errors = 0;
  int              checked = 0;
  int              seed = 32'h0000_1481;
  logic [31:0]     md [2**AW];
  logic [3:0]      mx [2**AW];
  logic [37:0]     exq[$];
  logic            act, dir_wr;
  logic [AW-1:0]   base;
  logic [1:0]      cnt;

  always #12.5 mclk = ~mclk;

  pbs_sram_port #(.AW(AW), .LANES(4)) dut_u (
    .mclk(mclk), .arst_n(arst_n), .address(address),
    .read_write_n(read_write_n), .advance_or_load(advance_or_load),
    .chip_sel1_n(chip_sel1_n), .chip_sel2_n(chip_sel2_n),
    .chip_sel_high(chip_sel_high), .clock_enable_n(clock_enable_n),
    .byte_write_sel_n(byte_write_sel_n), .output_en_n(output_en_n),
    .burst_order_sel(burst_order_sel), .sleep_request(sleep_request),
    .dq_in(dq_in), .dq_out(dq_out), .lane_extra_bits_in(lane_extra_bits_in),
    .lane_extra_bits_out(lane_extra_bits_out), .dq_oe(dq_oe));

  pbs_ctrl_model #(.AW(AW)) ctl_u (
    .mclk(mclk), .arst_n(arst_n), .address(address),
    .read_write_n(read_write_n), .advance_or_load(advance_or_load),
    .chip_sel1_n(chip_sel1_n), .chip_sel2_n(chip_sel2_n),
    .chip_sel_high(chip_sel_high), .clock_enable_n(clock_enable_n),
    .sleep_request(sleep_request), .byte_write_sel_n(byte_write_sel_n),
    .dq_in(dq_in), .lane_extra_bits_in(lane_extra_bits_in),
    .dq_out(dq_out), .lane_extra_bits_out(lane_extra_bits_out),
    .dq_oe(dq_oe));

  task automatic check(input string what, input logic [35:0] seen,
                       input logic [35:0] want);
    checked++;
    if (seen !== want) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic logic [1:0] beat_low(logic [1:0] s, logic [1:0] c);
    return burst_order_sel ? (s ^ c) : (s + c);
  endfunction

  // Reference model: works out each slot as the command is issued
  task automatic go(input int k, input logic rw, input logic [AW-1:0] a,
                    input logic [3:0] bw);
    logic [35:0]   wd;
    logic [AW-1:0] sa;
    logic [2:0]    cs;
    logic          wr;
    logic          rd;
    wd[31:0] = $random(seed);
    wd[35:32] = 4'($random(seed));
    cs = (k == 0) ? 3'h1 : 3'($random(seed));
    wr = 1'h0;
    rd = 1'h0;
    sa = a;
    // Any false select makes a stop
    while (k == 2 && cs == 3'h1) cs = 3'($random(seed));
    if (k == 0) begin
      act = 1'h1;
      dir_wr = !rw;
      base = a;
      cnt = 2'h0;
    end else if (k == 1 && act) begin
      cnt = cnt + 2'h1;
      sa = {base[AW-1:2], beat_low(base[1:0], cnt)};
    end else if (k == 2) begin
      act = 1'h0;
    end
    if (k == 0 || (k == 1 && act)) begin
      wr = dir_wr;
      rd = !dir_wr;
    end
    for (int j = 0; j < 4; j++) begin
      if (wr && !bw[j]) begin
        md[sa][8*j +: 8] = wd[8*j +: 8];
        mx[sa][j] = wd[32+j];
      end
    end
    if (k < 3) exq.push_back({rd, rd, rd ? {mx[sa], md[sa]} : 36'h0});
    ctl_u.step(k, (k == 0) ? a : AW'($random(seed)),
               (k == 0) ? rw : 1'($random(seed)), bw, cs, wd, wr);
  endtask

  task automatic do_reset(input logic order);
    go(3, 1'h0, '0, 4'hf);
    arst_n = 1'h0;
    burst_order_sel = order;
    repeat (16) @(posedge mclk);
    #1;
    arst_n = 1'h1;
    ctl_u.obs.delete();
    exq.delete();
    exq.push_back(38'h0);
    exq.push_back(38'h0);
    act = 1'h0;
    repeat (3) go(3, 1'h0, '0, 4'hf);
    check("drive enable", 36'(dq_oe), 36'h0);
  endtask

  task automatic drain();
    logic [36:0] o;
    logic [37:0] e;
    check("slot count", 36'(exq.size() - ctl_u.obs.size()), 36'h2);
    while (exq.size() > 2 && ctl_u.obs.size() > 0) begin
      o = ctl_u.obs.pop_front();
      e = exq.pop_front();
      check("drive enable", 36'(o[36]), 36'(e[36]));
      if (e[37]) check("read data", o[35:0], e[35:0]);
    end
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end

  initial begin
    int r;
    int k;
    for (int p = 0; p < 2; p++) begin
      do_reset(p == 0);
      for (int i = 0; i < 2**AW && p == 0; i++) go(0, 1'h0, AW'(i), 4'h0);
      go(0, 1'h0, 6'h05, 4'h0);
      repeat (7) go(1, 1'($random(seed)), '0, 4'($random(seed)));
      go(0, 1'h1, 6'h06, 4'h0);
      repeat (7) go(1, 1'($random(seed)), '0, 4'h0);
      go(3, 1'h0, '0, 4'h0);
      @(negedge mclk);
      check("drive enable", 36'(dq_oe), 36'h1);
      output_en_n = 1'h1;
      #1;
      check("forced off", 36'(dq_oe), 36'h0);
      // Gate held over a suspended edge while a read still drives
      @(posedge mclk);
      #1;
      output_en_n = 1'h0;
      go(0, 1'h0, 6'h09, 4'h5);
      go(0, 1'h1, 6'h09, 4'h0);
      go(0, 1'h0, 6'h09, 4'hf);
      go(0, 1'h1, 6'h09, 4'h0);
      go(0, 1'h0, 6'h0c, 4'h0);
      go(0, 1'h1, 6'h0c, 4'h0);
      go(1, 1'h0, '0, 4'h0);
      go(2, 1'h0, '0, 4'h0);
      go(1, 1'h0, '0, 4'h0);
      go(0, 1'h1, 6'h0d, 4'h0);
      go(3, 1'h0, '0, 4'h0);
      go(4, 1'h0, '0, 4'h0);
      go(1, 1'h0, '0, 4'h0);
      repeat (300) begin
        r = $unsigned($random(seed)) % 20;
        k = (r < 8) ? 0 : (r < 15) ? 1 : (r < 17) ? 2 : (r < 19) ? 3 : 4;
        go(k, 1'($random(seed)), AW'($random(seed)), 4'($random(seed)));
      end
      // Two stops flush pending writes before the next reset
      repeat (2) go(2, 1'h0, '0, 4'hf);
      go(3, 1'h0, '0, 4'hf);
      drain();
    end
    give_verdict();
  end
endmodule // pbs_sram_port_tb
